// [tlb_index_random_regs.sv]
`timescale 1ns/1ns
// Operation
// RULE_01 - read/write fields return hardware updates and hardware uses software writes
// RULE_02 - read-only fields ignore software writes and return hardware's last value
// RULE_03 - preset read-only fields are loaded at reset; undefined ones change only when documented
// RULE_04 - zero fields are never updated by hardware and read as zero
// RULE_05 - a 32-bit entry select register gives the entry for probe, read, indexed write
// RULE_06 - low index field is read/write and names the indexed read/write entry
// RULE_07 - top bit set by hardware when last probe found no match; read-only
// RULE_08 - unused bits of both registers read as zero; software writes zero
// RULE_09 - software must not write an index at or above the entry count
// RULE_10 - field widths cover ceiling log2 of the entry count
// RULE_11 - replacement pointer low field is read-only and feeds the random write
// RULE_12 - replacement pointer never goes below the wired count
// RULE_13 - replacement pointer upper bound is entry count minus one
// RULE_14 - pointer decrements nearly every clock, wrapping from wired count to top
// RULE_15 - a shift register pseudo-randomly suppresses some decrements
// RULE_16 - pointer reloads to top on reset and on each wired count write
// RULE_17 - registers read as reserved zero when a fixed mapping unit is fitted
// RULE_18 - a separate wired count register holds the entries kept from replacement
// RULE_19 - a wired count write wins over a coincident decrement
module tlb_index_random_regs (
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    input  wire logic        fixed_mapping_unit_in,
    input  wire logic [4:0]  reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic [31:0] reg_wdata_in,
    output logic [31:0]      reg_rdata_out,
    input  wire logic        tlb_probe_done_in,
    input  wire logic        tlb_probe_hit_in,
    input  wire logic [3:0]  tlb_probe_index_in,
    output logic [3:0]       entry_index_out,
    output logic [3:0]       replace_index_out,
    output logic [3:0]       wired_count_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [3:0]               index_q;
    logic [3:0]               index_d;
    logic                     probe_fail_q;
    logic                     probe_fail_d;
    logic [3:0]               ptr_q;
    logic [3:0]               ptr_d;
    tlb_index_pkg::ptr_state_t state_q;
    tlb_index_pkg::ptr_state_t state_d;
    logic [31:0]              rdata_d;

    logic                     pause;
    logic [3:0]               wired;
    logic                     wired_written;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [4:0] addr, input logic [4:0] reg_no);
        hit = (addr == reg_no);
    endfunction

    logic tlb_present;
    logic wr_select;
    logic wr_wired;

    // RULE_17 reserved when fixed
    assign tlb_present = ~fixed_mapping_unit_in;
    assign wr_select   = reg_wr_in & tlb_present & hit(reg_addr_in, tlb_index_pkg::REG_ENTRY_SELECT);
    // RULE_02 pointer writes ignored
    assign wr_wired    = reg_wr_in & tlb_present & hit(reg_addr_in, tlb_index_pkg::REG_WIRED_COUNT);

    // ------------------------------------------------------------
    // wired count and pause source
    // ------------------------------------------------------------
    // RULE_18 wired count held
    wired_count_reg u_wired (
        .mclk_in     (mclk_in),
        .reset_in    (reset_in),
        .wr_en_in    (wr_wired),
        .wr_data_in  (reg_wdata_in[3:0]),
        .wired_out   (wired),
        .written_out (wired_written)
    );

    // RULE_15 random pause
    pause_lfsr u_lfsr (
        .mclk_in   (mclk_in),
        .reset_in  (reset_in),
        .pause_out (pause)
    );

    // ------------------------------------------------------------
    // entry select register
    // ------------------------------------------------------------
    // RULE_01 software and probe
    // RULE_06 low index field
    // a probe hit wins over a same-cycle software write
    assign index_d = (tlb_probe_done_in & tlb_probe_hit_in) ? tlb_probe_index_in :
                     wr_select ? reg_wdata_in[3:0] : index_q;

    // RULE_07 probe failure flag
    assign probe_fail_d = tlb_probe_done_in ? ~tlb_probe_hit_in : probe_fail_q;

    // ------------------------------------------------------------
    // replacement pointer
    // ------------------------------------------------------------
    logic       at_floor;
    logic       below_floor;
    logic [3:0] ptr_dec;

    assign at_floor    = (ptr_q == wired);
    // wired above the pointer after a write is covered by the reload
    assign below_floor = (ptr_q < wired);
    assign ptr_dec     = ptr_q - 4'h0_001;

    always_comb begin
        state_d = state_q;
        ptr_d   = ptr_q;
        case (state_q)
            tlb_index_pkg::PTR_RESET: begin
                // RULE_16 reload after reset
                // RULE_13 upper bound
                ptr_d   = tlb_index_pkg::IDX_TOP;
                state_d = tlb_index_pkg::PTR_RUN;
            end
            tlb_index_pkg::PTR_RUN: begin
                if (wired_written | below_floor) begin
                    // RULE_16 reload on wired write
                    // RULE_19 reload wins
                    ptr_d = tlb_index_pkg::IDX_TOP;
                end else if (!pause) begin
                    // RULE_14 decrement and wrap
                    // RULE_12 floor at wired
                    ptr_d = at_floor ? tlb_index_pkg::IDX_TOP : ptr_dec;
                end
            end
            default: begin
                ptr_d   = tlb_index_pkg::IDX_TOP;
                state_d = tlb_index_pkg::PTR_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [31:0] select_word;
    logic [31:0] pointer_word;
    logic [31:0] wired_word;

    // RULE_04 zero fields
    // RULE_08 unused bits zero
    assign select_word  = {probe_fail_q, tlb_index_pkg::MID_ZERO, index_q};
    // RULE_11 read-only pointer
    assign pointer_word = {28'h000_0000, ptr_q};
    assign wired_word   = {28'h000_0000, wired};

    always_comb begin
        rdata_d = tlb_index_pkg::WORD_ZERO;
        if (tlb_present) begin
            if (hit(reg_addr_in, tlb_index_pkg::REG_ENTRY_SELECT)) begin
                rdata_d = select_word;
            end else if (hit(reg_addr_in, tlb_index_pkg::REG_REPLACE_POINTER)) begin
                rdata_d = pointer_word;
            end else if (hit(reg_addr_in, tlb_index_pkg::REG_WIRED_COUNT)) begin
                rdata_d = wired_word;
            end
        end
    end

    // ------------------------------------------------------------
    // flops
    // ------------------------------------------------------------
    // RULE_03 preset pointer at reset
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state_q       <= tlb_index_pkg::PTR_RESET;
            ptr_q         <= tlb_index_pkg::IDX_TOP;
            index_q       <= tlb_index_pkg::IDX_ZERO;
            probe_fail_q  <= 1'b0;
            reg_rdata_out <= tlb_index_pkg::WORD_ZERO;
        end else begin
            state_q       <= state_d;
            ptr_q         <= ptr_d;
            index_q       <= index_d;
            probe_fail_q  <= probe_fail_d;
            reg_rdata_out <= rdata_d;
        end
    end

    // RULE_05 entry to the array
    // RULE_10 four bits for sixteen
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            entry_index_out   <= tlb_index_pkg::IDX_ZERO;
            replace_index_out <= tlb_index_pkg::IDX_TOP;
            wired_count_out   <= tlb_index_pkg::IDX_ZERO;
        end else begin
            entry_index_out   <= index_d;
            replace_index_out <= ptr_d;
            wired_count_out   <= wired;
        end
    end
endmodule

// [tlb_index_pkg.sv]
package tlb_index_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int unsigned TLB_ENTRIES   = 16;
    localparam int unsigned IDX_W         = 4;
    localparam logic [3:0]  IDX_TOP       = 4'h0_00F;
    localparam logic [3:0]  IDX_ZERO      = 4'h0_000;

    // ------------------------------------------------------------
    // register map (register numbers of the coprocessor)
    // ------------------------------------------------------------
    localparam logic [4:0]  REG_ENTRY_SELECT    = 5'h0_000;
    localparam logic [4:0]  REG_REPLACE_POINTER = 5'h0_001;
    localparam logic [4:0]  REG_WIRED_COUNT     = 5'h0_006;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int unsigned PROBE_FAIL_BIT = 31;
    localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
    localparam logic [26:0] MID_ZERO       = 27'h000_0000;

    // ------------------------------------------------------------
    // pause generator
    // ------------------------------------------------------------
    localparam logic [7:0]  LFSR_SEED = 8'h0_0A5;
    localparam logic [7:0]  LFSR_TAPS = 8'h0_0B8;

    typedef enum logic [1:0] {
        PTR_RESET,
        PTR_RUN
    } ptr_state_t;
endpackage

// [pause_lfsr.sv]
`timescale 1ns/1ns
// galois shift register; a high out bit holds the pointer for one clock
module pause_lfsr (
    input  wire logic mclk_in,
    input  wire logic reset_in,
    output logic      pause_out
);
    logic [7:0] lfsr_q;
    logic [7:0] lfsr_d;

    assign lfsr_d = lfsr_q[0] ? ((lfsr_q >> 1) ^ tlb_index_pkg::LFSR_TAPS) : (lfsr_q >> 1);

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            lfsr_q    <= tlb_index_pkg::LFSR_SEED;
            pause_out <= 1'b0;
        end else begin
            lfsr_q    <= lfsr_d;
            // pause about one clock in four so the sequence stays mostly decrementing
            pause_out <= lfsr_q[0] & lfsr_q[3];
        end
    end
endmodule

// [wired_count_reg.sv]
`timescale 1ns/1ns
// wired-entry count with a one-clock write strobe for the pointer reload
module wired_count_reg (
    input  wire logic       mclk_in,
    input  wire logic       reset_in,
    input  wire logic       wr_en_in,
    input  wire logic [3:0] wr_data_in,
    output logic [3:0]      wired_out,
    output logic            written_out
);
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            wired_out   <= tlb_index_pkg::IDX_ZERO;
            written_out <= 1'b0;
        end else begin
            written_out <= wr_en_in;
            if (wr_en_in) begin
                wired_out <= wr_data_in;
            end
        end
    end
endmodule

// [tlb_index_random_regs_props.sv]
`timescale 1ns/1ns
module tlb_index_random_regs_props (
    input wire logic        mclk_in,
    input wire logic        reset_in,
    input wire logic        fixed_mapping_unit_in,
    input wire logic [4:0]  reg_addr_in,
    input wire logic        reg_wr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic        tlb_probe_done_in,
    input wire logic        tlb_probe_hit_in,
    input wire logic [3:0]  tlb_probe_index_in,
    input wire logic [3:0]  entry_index_out,
    input wire logic [3:0]  replace_index_out,
    input wire logic [3:0]  wired_count_out
);
    logic [1:0] quiet_q;
    wire logic  no_tlb   = fixed_mapping_unit_in;
    wire logic  wired_wr = reg_wr_in && reg_addr_in == tlb_index_pkg::REG_WIRED_COUNT && !no_tlb;
    wire logic  settled  = quiet_q == 2'd3;
    // the wired output lags, so pointer bounds are judged once it settles
    always_ff @(posedge mclk_in) begin
        quiet_q <= (reset_in || wired_wr) ? 2'd0 : quiet_q + {1'b0, quiet_q != 2'd3};
    end
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);
    a_ptr_floor: assert property (settled |-> replace_index_out >= wired_count_out)
        else $error("pointer below wired count");
    a_ptr_step: assert property (settled && $changed(replace_index_out) |->
        replace_index_out == $past(replace_index_out) - 4'h1 || replace_index_out == 4'hF)
        else $error("pointer step wrong");
    a_ptr_wrap: assert property (settled && $past(replace_index_out) == $past(wired_count_out)
        && $changed(replace_index_out) |-> replace_index_out == 4'hF)
        else $error("pointer wrap wrong");
    a_wired_reload: assert property (wired_wr |-> ##2 replace_index_out == 4'hF)
        else $error("no reload after wired write");
    a_probe_hit: assert property (tlb_probe_done_in && tlb_probe_hit_in && !no_tlb |=>
        entry_index_out == $past(tlb_probe_index_in))
        else $error("probe hit index not loaded");
    a_miss_keeps: assert property (tlb_probe_done_in && !tlb_probe_hit_in && !reg_wr_in |=>
        $stable(entry_index_out))
        else $error("probe miss changed index");
    a_sw_index: assert property (reg_wr_in && reg_addr_in == tlb_index_pkg::REG_ENTRY_SELECT
        && !tlb_probe_done_in && !no_tlb |=> entry_index_out == $past(reg_wdata_in[3:0]))
        else $error("index write lost");
    a_read_index: assert property (!$past(reset_in) && !$past(no_tlb) && $past(reg_addr_in) ==
        tlb_index_pkg::REG_ENTRY_SELECT |-> reg_rdata_out[3:0] == $past(entry_index_out))
        else $error("index read mismatch");
    a_mid_zero: assert property (reg_rdata_out[30:4] == tlb_index_pkg::MID_ZERO)
        else $error("reserved bits not zero");
    a_fixed_zero: assert property ($past(no_tlb) |-> reg_rdata_out == tlb_index_pkg::WORD_ZERO)
        else $error("reserved register not zero");
endmodule
bind tlb_index_random_regs tlb_index_random_regs_props u_props (.mclk_in(mclk_in),
    .reset_in(reset_in), .fixed_mapping_unit_in(fixed_mapping_unit_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .tlb_probe_done_in(tlb_probe_done_in),
    .tlb_probe_hit_in(tlb_probe_hit_in), .tlb_probe_index_in(tlb_probe_index_in),
    .entry_index_out(entry_index_out), .replace_index_out(replace_index_out),
    .wired_count_out(wired_count_out));

// [probe_pipe_model.sv]
`timescale 1ns/1ns
module probe_pipe_model (
    input  wire logic mclk_in,
    output logic      done_out = 1'b0,
    output logic      hit_out = 1'b0,
    output logic [3:0] idx_out = 4'h0
);
    task automatic probe(input logic hit, input logic [3:0] idx, input int lat);
        repeat (lat) @(posedge mclk_in);
        done_out <= 1'b1;
        hit_out  <= hit;
        idx_out  <= idx;
        @(posedge mclk_in);
        // released lines flip so a stale value is never trusted
        done_out <= 1'b0;
        hit_out  <= ~hit;
        idx_out  <= ~idx;
    endtask
endmodule

// [tlb_index_random_regs_tb.sv]
`timescale 1ns/1ns
module tlb_index_random_regs_tb;
    logic        mclk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        fixed_mapping_unit_in = 1'b0;
    logic [4:0]  reg_addr_in = 5'h00;
    logic        reg_wr_in = 1'b0;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic [31:0] reg_rdata_out;
    logic        tlb_probe_done_in, tlb_probe_hit_in;
    logic [3:0]  tlb_probe_index_in, entry_index_out, replace_index_out, wired_count_out;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cycles = 0;
    probe_pipe_model pm (.mclk_in(mclk_in), .done_out(tlb_probe_done_in),
        .hit_out(tlb_probe_hit_in), .idx_out(tlb_probe_index_in));
    tlb_index_random_regs dut (.mclk_in(mclk_in), .reset_in(reset_in),
        .fixed_mapping_unit_in(fixed_mapping_unit_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .tlb_probe_done_in(tlb_probe_done_in), .tlb_probe_hit_in(tlb_probe_hit_in),
        .tlb_probe_index_in(tlb_probe_index_in), .entry_index_out(entry_index_out),
        .replace_index_out(replace_index_out), .wired_count_out(wired_count_out));
    initial forever #20 mclk_in = ~mclk_in;
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 1000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        reg_addr_in  <= a;
        reg_wr_in    <= 1'b1;
        reg_wdata_in <= d;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] v);
        reg_addr_in <= a;
        @(posedge mclk_in);
        #1 v = reg_rdata_out;
        @(posedge mclk_in);
    endtask
    task automatic t_reset;
        reset_in <= 1'b1;
        repeat (12) @(posedge mclk_in);
        reset_in <= 1'b0;
        #1 chk("pointer", 32'hF, replace_index_out);
        chk("index", 32'h0, entry_index_out);
        chk("wired", 32'h0, wired_count_out);
        @(posedge mclk_in);
        $display("t_reset done");
    endtask
    task automatic t_regs;
        logic [31:0] v;
        wr(5'h00, 32'h0000_0005);
        rd(5'h00, v);
        chk("select", 32'h0000_0005, v);
        wr(5'h00, 32'h0000_000F);
        wr(5'h01, 32'h0000_0003);
        rd(5'h00, v);
        chk("select", 32'h0000_000F, v);
        rd(5'h01, v);
        chk("pointer high", 32'h0, v & 32'hFFFF_FFF0);
        rd(5'h07, v);
        chk("unmapped", 32'h0, v);
        $display("t_regs done");
    endtask
    task automatic t_probe;
        logic [31:0] v;
        pm.probe(1'b0, 4'h2, 1);
        rd(5'h00, v);
        chk("miss", 32'h8000_000F, v);
        pm.probe(1'b1, 4'h3, 2);
        rd(5'h00, v);
        chk("hit", 32'h0000_0003, v);
        pm.probe(1'b0, 4'h9, 1);
        wr(5'h00, 32'h0000_0006);
        rd(5'h00, v);
        chk("flag kept", 32'h8000_0006, v);
        $display("t_probe done");
    endtask
    task automatic t_wired;
        logic [3:0] p, q;
        logic [31:0] v;
        int pauses, wraps;
        pauses = 0;
        wraps = 0;
        wr(5'h06, 32'h0000_000A);
        #1 chk("reload", 32'hF, replace_index_out);
        p = replace_index_out;
        repeat (64) begin
            @(posedge mclk_in);
            #1 q = replace_index_out;
            if (q == p) pauses++;
            else if (q == 4'hF && p == 4'hA) wraps++;
            else chk("step", p - 4'h1, q);
            chk("floor", 32'h1, q >= 4'hA);
            p = q;
        end
        chk("paused", 32'h1, pauses > 0);
        chk("wrapped", 32'h1, wraps > 0);
        chk("wired out", 32'hA, wired_count_out);
        rd(5'h06, v);
        chk("wired reg", 32'h0000_000A, v);
        wr(5'h06, 32'h0000_000F);
        repeat (8) @(posedge mclk_in);
        #1 chk("full wired", 32'hF, replace_index_out);
        @(posedge mclk_in);
        // pointer parked at top, so a stray load of the write data would show at once
        reg_addr_in  <= 5'h01;
        reg_wr_in    <= 1'b1;
        reg_wdata_in <= 32'h0000_0003;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        #1 chk("pointer ro", 32'hF, replace_index_out);
        @(posedge mclk_in);
        $display("t_wired done");
    endtask
    task automatic t_fixed;
        logic [31:0] v;
        fixed_mapping_unit_in <= 1'b1;
        wr(5'h00, 32'h0000_0001);
        rd(5'h00, v);
        chk("fixed select", 32'h0, v);
        rd(5'h01, v);
        chk("fixed pointer", 32'h0, v);
        fixed_mapping_unit_in <= 1'b0;
        rd(5'h00, v);
        chk("select kept", 32'h8000_0006, v);
        $display("t_fixed done");
    endtask
    initial begin
        t_reset();
        t_regs();
        t_probe();
        t_wired();
        t_fixed();
        t_reset();
        report_and_stop();
    end
endmodule
